// ===== aimes_pkg.sv
// shared constants and types for the mux expansion sequencer
package aimes_pkg;
   // converter bus: 3-bit address inside its 8-byte space, 8-bit data
   localparam int unsigned BUS_ADDR_W = 3;
   localparam int unsigned BUS_DATA_W = 8;
   localparam logic [BUS_ADDR_W-1:0] ADDR_CTRL = 3'h0;
   localparam logic [BUS_ADDR_W-1:0] ADDR_OP_COUNT = 3'h6;
   localparam logic [BUS_ADDR_W-1:0] ADDR_SPARE = 3'h7;
   localparam int unsigned RUN_BIT = 0;
   localparam logic RUN_RESET = 1'b0;

   // channel counter
   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;
   localparam int unsigned LIMIT_W = 4;
   localparam logic [LIMIT_W-1:0] LIMIT_RESET = 4'h0;

   // field positions of the counter per variant
   localparam int unsigned SEL_W = 3;
   localparam int unsigned EN_W = 8;
   localparam int unsigned MUX_ADDR_W = 4;
   localparam int unsigned SPARE_W = 2;
   localparam int unsigned DIFF_SEL_LSB = 3;
   localparam int unsigned SE_SEL_LSB = 4;
   localparam int unsigned DIFF_SPARE_LSB = 6;
   localparam int unsigned SE_SPARE_BIT = 7;
   localparam logic [EN_W-1:0] SINGLE_MUX_EN = 8'h01;

   typedef enum logic [1:0] {
      AIMES_V64_DIFF,
      AIMES_V128_SE,
      AIMES_V8_PROG
   } aimes_variant_t;

   // one bus cycle as seen at the converter's pins
   typedef struct packed {
      logic wr;
      logic [BUS_ADDR_W-1:0] addr;
      logic [BUS_DATA_W-1:0] data;
   } aimes_bus_t;

   // external multiplexer controls
   typedef struct packed {
      logic [MUX_ADDR_W-1:0] addr;
      logic [EN_W-1:0] en;
      logic [SPARE_W-1:0] spare;
   } aimes_mux_t;
endpackage

// ===== aimes_onehot_dec.sv
// one-of-n decoder for multiplexer chip enables
module aimes_onehot_dec #(
   parameter int unsigned SEL_W = 3
) (
   input wire logic [SEL_W-1:0] i_sel,
   output logic [(2**SEL_W)-1:0] o_onehot
);
   localparam logic [(2**SEL_W)-1:0] ONE = {{((2**SEL_W)-1){1'b0}}, 1'b1};
   assign o_onehot = ONE << i_sel;
endmodule

// ===== aimes_sequencer.sv
// channel sequencer that widens the converter input multiplexer
// Functional notes
// - each strobe rising edge outside hold, armed load or limit wrap steps counter by one
// - sequence done reloads channel one for resync
// - converter reset or stopped holds clear active
// - first strobe in run clears counter, ends hold
// - done rising edge arms an active-low load
// - next strobe loads one, disarms load
// - 64-channel: three low bits address muxes
// - 64-channel: bits five..three decode eight enables
// - 64-channel: two spare counter bits offered for expansion
// - control register write latches the run bit
// - 128-channel: four low bits address muxes
// - 128-channel: enable decode one bit higher
// - 8-channel: address six stores operation count
// - 8-channel: compare match wraps counter to zero
// - only address six is claimed; address zero is snooped for run
module aimes_sequencer
   import aimes_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire aimes_variant_t i_variant,
   input wire logic i_op_strobe,
   input wire logic i_sequence_done_flag,
   input wire logic i_conv_reset,
   input wire aimes_bus_t i_bus,
   output aimes_mux_t o_mux,
   output logic o_counter_clear_n,
   output logic o_load_arm_n,
   output logic o_run
);
   ////////////////////////////////////////////////////////////////////////////
   // edge detection of converter pins
   logic strobe_d_reg;
   logic done_d_reg;
   wire strobe_rise = i_op_strobe & ~strobe_d_reg;
   wire done_rise = i_sequence_done_flag & ~done_d_reg;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         strobe_d_reg <= 1'b0;
         done_d_reg <= 1'b0;
      end else begin
         strobe_d_reg <= i_op_strobe;
         done_d_reg <= i_sequence_done_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus decode; the converter answers the other addresses itself
   logic run_reg;
   logic [LIMIT_W-1:0] limit_reg;
   wire wr_ctrl = i_bus.wr & (i_bus.addr == ADDR_CTRL);
   wire wr_limit = i_bus.wr & (i_bus.addr == ADDR_OP_COUNT);
   // a converter reset also stops it, so the run copy drops too
   wire run_next = i_conv_reset ? RUN_RESET : (wr_ctrl ? i_bus.data[RUN_BIT] : run_reg);
   wire [LIMIT_W-1:0] limit_next = wr_limit ? i_bus.data[LIMIT_W-1:0] : limit_reg;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         run_reg <= RUN_RESET;
         limit_reg <= LIMIT_RESET;
      end else begin
         run_reg <= run_next;
         limit_reg <= limit_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hold and load-arm flip-flops
   logic hold_reg;
   logic arm_reg;
   wire stopped = i_conv_reset | ~run_reg;
   // the stop level wins over the strobe so no count slips out while halted
   wire hold_next = stopped ? 1'b1 : (strobe_rise ? 1'b0 : hold_reg);
   // a done edge in the same cycle as the strobe keeps the load armed
   wire arm_next = done_rise ? 1'b1 : (strobe_rise ? 1'b0 : arm_reg);

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hold_reg <= 1'b1;
         arm_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
         arm_reg <= arm_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel counter
   logic [CNT_W-1:0] cnt_reg;
   wire is_v8 = (i_variant == AIMES_V8_PROG);
   wire limit_hit = is_v8 & (cnt_reg[LIMIT_W-1:0] == limit_reg);
   wire [CNT_W-1:0] cnt_inc = cnt_reg + CNT_STEP;
   wire [CNT_W-1:0] cnt_step = hold_reg ? CNT_ZERO :
                               arm_reg ? CNT_ONE :
                               limit_hit ? CNT_ZERO : cnt_inc;
   wire [CNT_W-1:0] cnt_next = strobe_rise ? cnt_step : cnt_reg;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) cnt_reg <= CNT_ZERO;
      else cnt_reg <= cnt_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // multiplexer control, registered from the next count
   logic [EN_W-1:0] en_diff;
   logic [EN_W-1:0] en_se;
   aimes_mux_t mux_next;
   aimes_mux_t mux_reg;

   aimes_onehot_dec #(.SEL_W(SEL_W)) u_dec_diff (
      .i_sel(cnt_next[DIFF_SEL_LSB +: SEL_W]),
      .o_onehot(en_diff)
   );
   aimes_onehot_dec #(.SEL_W(SEL_W)) u_dec_se (
      .i_sel(cnt_next[SE_SEL_LSB +: SEL_W]),
      .o_onehot(en_se)
   );

   wire [MUX_ADDR_W-1:0] addr_diff = {1'b0, cnt_next[SEL_W-1:0]};
   wire [MUX_ADDR_W-1:0] addr_se = cnt_next[MUX_ADDR_W-1:0];
   wire [SPARE_W-1:0] spare_diff = cnt_next[DIFF_SPARE_LSB +: SPARE_W];
   wire [SPARE_W-1:0] spare_se = {1'b0, cnt_next[SE_SPARE_BIT]};

   always_comb begin
      mux_next = '0;
      case (i_variant)
         AIMES_V64_DIFF: begin
            mux_next.addr = addr_diff;
            mux_next.en = en_diff;
            mux_next.spare = spare_diff;
         end
         AIMES_V128_SE: begin
            mux_next.addr = addr_se;
            mux_next.en = en_se;
            mux_next.spare = spare_se;
         end
         AIMES_V8_PROG: begin
            mux_next.addr = addr_diff;
            mux_next.en = SINGLE_MUX_EN;
         end
         default: mux_next = '0;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) mux_reg <= '0;
      else mux_reg <= mux_next;
   end

   assign o_mux = mux_reg;
   assign o_counter_clear_n = ~hold_reg;
   assign o_load_arm_n = ~arm_reg;
   assign o_run = run_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_strobe;
      strobe_rise;
   endsequence
   sequence s_plain_step;
      strobe_rise && !hold_reg && !arm_reg && !limit_hit;
   endsequence

   a_hold_clears_cnt: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      s_strobe and hold_reg |=> cnt_reg == CNT_ZERO)
      else $error("held strobe did not clear counter");
   a_armed_loads_one: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      s_strobe and (!hold_reg && arm_reg) |=> cnt_reg == CNT_ONE)
      else $error("armed strobe did not load one");
   a_step_by_one: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      s_plain_step |=> cnt_reg == $past(cnt_reg) + CNT_STEP)
      else $error("counter did not step by one");
   a_quiet_hold_cnt: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      !strobe_rise |=> $stable(cnt_reg))
      else $error("counter moved without strobe");
   a_done_arms_load: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      done_rise |=> !o_load_arm_n)
      else $error("done edge did not arm load");
   a_arm_stays_set: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      !o_load_arm_n && !strobe_rise |=> !o_load_arm_n)
      else $error("armed load dropped without strobe");
   a_strobe_disarms: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      s_strobe and !done_rise |=> o_load_arm_n)
      else $error("strobe did not disarm load");
   a_stop_forces_clr: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      i_conv_reset |=> !o_run && !o_counter_clear_n)
      else $error("converter reset did not force clear");
   a_run_write_hold: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      wr_ctrl && !i_conv_reset && !i_bus.data[RUN_BIT] |=> !o_run ##1 !o_counter_clear_n)
      else $error("run clear write did not hold counter");
   a_limit_wraps: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      strobe_rise && is_v8 && !hold_reg && !arm_reg && cnt_reg[LIMIT_W-1:0] == limit_reg
      |=> cnt_reg == CNT_ZERO)
      else $error("count limit did not wrap counter");
   a_diff_addr_track: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      i_variant == AIMES_V64_DIFF |=> o_mux.addr == {1'b0, cnt_reg[SEL_W-1:0]} && $onehot(o_mux.en))
      else $error("mux address does not follow counter");
   a_se_enable_track: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      i_variant == AIMES_V128_SE |=> o_mux.en[cnt_reg[SE_SEL_LSB +: SEL_W]] && o_mux.addr == cnt_reg[MUX_ADDR_W-1:0])
      else $error("128-channel enable does not follow counter");
endmodule

// ===== aimes_conv_model.sv
// converter partner model: strobe, done and reset pins plus host bus writes
module aimes_conv_model
   import aimes_pkg::*;
(
   input wire logic i_core_clk,
   output logic o_op_strobe,
   output logic o_sequence_done_flag,
   output logic o_conv_reset,
   output aimes_bus_t o_bus
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_op_strobe = 1'b0;
      o_sequence_done_flag = 1'b0;
      o_conv_reset = 1'b0;
      o_bus = '0;
   end
   ////////////////////////////////////////////////////////////////
   // strobe pin kept as a dedicated output; gap gives prompt or slow pacing
   task automatic op(input int gap);
      @(negedge i_core_clk) o_op_strobe = 1'b1;
      repeat (2) @(negedge i_core_clk);
      o_op_strobe = 1'b0;
      repeat (gap) @(negedge i_core_clk);
   endtask
   task automatic done_edge();
      @(negedge i_core_clk) o_sequence_done_flag = 1'b1;
      repeat (2) @(negedge i_core_clk);
      o_sequence_done_flag = 1'b0;
   endtask
   // a full group: eight like operations, then sequence done
   task automatic group8();
      repeat (8) op(1);
      done_edge();
   endtask
   task automatic write(input logic [BUS_ADDR_W-1:0] a, input logic [BUS_DATA_W-1:0] d);
      @(negedge i_core_clk) o_bus = '{1'b1, a, d};
      @(negedge i_core_clk) o_bus.wr = 1'b0;
      repeat (2) @(negedge i_core_clk);
   endtask
   task automatic set_reset(input logic v);
      @(negedge i_core_clk) o_conv_reset = v;
      repeat (2) @(negedge i_core_clk);
   endtask
endmodule

// ===== aimes_sequencer_bench.sv
// self-checking bench for the mux expansion sequencer
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module aimes_sequencer_bench;
   import aimes_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_core_clk = 1'b0;
   logic i_arst_n = 1'b0;
   aimes_variant_t i_variant = AIMES_V64_DIFF;
   logic op_strobe, done_flag, conv_reset;
   aimes_bus_t bus;
   aimes_mux_t o_mux;
   logic o_counter_clear_n, o_load_arm_n, o_run;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [CNT_W-1:0] cnt;

   aimes_conv_model aimes_conv_model_inst (.i_core_clk(i_core_clk), .o_op_strobe(op_strobe),
      .o_sequence_done_flag(done_flag), .o_conv_reset(conv_reset), .o_bus(bus));
   aimes_sequencer aimes_sequencer_inst (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
      .i_variant(i_variant), .i_op_strobe(op_strobe), .i_sequence_done_flag(done_flag),
      .i_conv_reset(conv_reset), .i_bus(bus), .o_mux(o_mux), .o_counter_clear_n(o_counter_clear_n),
      .o_load_arm_n(o_load_arm_n), .o_run(o_run));

   initial begin
      forever #25 i_core_clk = ~i_core_clk;
   end
   ////////////////////////////////////////////////////////////////
   function automatic aimes_mux_t exp_mux(aimes_variant_t v, logic [CNT_W-1:0] c);
      case (v)
         AIMES_V64_DIFF: return {1'b0, c[2:0], 8'h01 << c[5:3], c[7:6]};
         AIMES_V128_SE: return {c[3:0], 8'h01 << c[6:4], 1'b0, c[7]};
         default: return {1'b0, c[2:0], SINGLE_MUX_EN, 2'h0};
      endcase
   endfunction
   task automatic complete_run();
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic do_reset(input aimes_variant_t v);
      @(negedge i_core_clk) i_arst_n = 1'b0;
      i_variant = v;
      repeat (4) @(negedge i_core_clk);
      i_arst_n = 1'b1;
      @(negedge i_core_clk);
      `CHK({o_counter_clear_n, o_load_arm_n, o_run}, 3'b010)
   endtask
   task automatic step(input logic [CNT_W-1:0] nxt);
      aimes_conv_model_inst.op(2);
      cnt = nxt;
      `CHK(o_mux, exp_mux(i_variant, cnt))
   endtask
   // run start: first strobe must give zero, not one
   task automatic start_run();
      aimes_conv_model_inst.write(ADDR_CTRL, 8'h01);
      `CHK(o_run, 1'b1)
      `CHK(o_counter_clear_n, 1'b0)
      step(CNT_ZERO);
      `CHK(o_counter_clear_n, 1'b1)
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic run_64();
      do_reset(AIMES_V64_DIFF);
      start_run();
      for (int k = 1; k < 66; k++) step(k[CNT_W-1:0]);
      aimes_conv_model_inst.done_edge();
      `CHK(o_load_arm_n, 1'b0)
      step(CNT_ONE);
      `CHK(o_load_arm_n, 1'b1)
      aimes_conv_model_inst.group8();
      step(CNT_ONE);
      aimes_conv_model_inst.set_reset(1'b1);
      `CHK({o_counter_clear_n, o_run}, 2'b00)
      // armed load pending while held: clear must still win
      aimes_conv_model_inst.done_edge();
      step(CNT_ZERO);
      aimes_conv_model_inst.set_reset(1'b0);
   endtask
   task automatic run_128();
      do_reset(AIMES_V128_SE);
      start_run();
      for (int k = 1; k < 130; k++) step(k[CNT_W-1:0]);
   endtask
   // limit 3 at address six; a write to seven must not disturb it
   task automatic run_8();
      do_reset(AIMES_V8_PROG);
      aimes_conv_model_inst.write(ADDR_OP_COUNT, 8'h03);
      aimes_conv_model_inst.write(ADDR_SPARE, 8'h0f);
      `CHK(o_run, 1'b0)
      start_run();
      repeat (6) step((cnt[3:0] == 4'h3) ? CNT_ZERO : cnt + CNT_STEP);
      // host stops the converter: run drops, then the clear is forced
      aimes_conv_model_inst.write(ADDR_CTRL, 8'h00);
      `CHK({o_run, o_counter_clear_n}, 2'b00)
      step(CNT_ZERO);
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      run_64();
      run_128();
      run_8();
      complete_run();
   end
endmodule
